// ===== common/synth_ctl_pkg.sv
package synth_ctl_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] reg_ref_scale = 8'h00;
  localparam logic [7:0] reg_cp_current = 8'h04;
  localparam logic [7:0] reg_loop_filter_rx = 8'h08;
  localparam logic [7:0] reg_loop_filter_tx = 8'h0c;
  localparam logic [7:0] reg_int_word_rx = 8'h10;
  localparam logic [7:0] reg_int_word_tx = 8'h14;
  localparam logic [7:0] reg_cal_ctrl = 8'h18;
  localparam logic [7:0] reg_lock_cfg = 8'h1c;
  localparam logic [7:0] reg_status = 8'h20;
  localparam logic [7:0] reg_mode = 8'h24;

  localparam logic [31:0] read_zero = 32'h0000_0000;
  localparam int ref_scaler_count = 3;
  localparam int cp_code_width = 6;
  localparam int lf_code_width = 4;
  localparam int lf_component_count = 5;
  localparam int int_low_width = 8;
  localparam int cal_len_width = 16;
  localparam logic [15:0] cal_len_reset = 16'h0040;

  // cal_ctrl field positions
  localparam int cal_len_lsb = 0;
  localparam int cal_inhibit_bit = 16;
  localparam int vtune_rx_bit = 17;
  localparam int vtune_tx_bit = 18;
  // lock_cfg field positions
  localparam int lock_count_lsb = 0;
  localparam int lock_mode_lsb = 2;
  // mode register positions
  localparam int mode_tdd_bit = 0;
  localparam int mode_pin_ctrl_bit = 1;

  localparam logic [11:0] lock_base_cycles = 12'h100;

  typedef enum logic [1:0] {
    scale_pass = 2'b00,
    scale_mul2 = 2'b01,
    scale_div2 = 2'b10,
    scale_div4 = 2'b11
  } ref_scale_t;

  typedef enum logic [1:0] {
    lock_off = 2'b00,
    lock_once = 2'b01,
    lock_cont = 2'b10,
    lock_unused = 2'b11
  } lock_mode_t;

  typedef enum logic [1:0] {
    st_wait = 2'b00,
    st_alert = 2'b01,
    st_rx = 2'b11,
    st_tx = 2'b10
  } radio_state_t;

  typedef enum logic [1:0] {
    syn_off = 2'b00,
    syn_cal = 2'b01,
    syn_locking = 2'b11,
    syn_locked = 2'b10
  } syn_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } avalon_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avalon_rsp_t;
endpackage : synth_ctl_pkg

// ===== rtl/rf_synth_cal_lock_control.sv
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - each reference scaler passes, doubles, halves or quarters the loop reference
// - three independently configured scalers: rx, tx and baseband synthesizers
// - rf charge pump current is a 6-bit code, 0.1 mA per step
// - rf loop filter has five components, each a 4-bit code
// - vco calibration starts on wait-to-alert, powerdown-to-alert, or integer word low write
// - tdd pin control in alert powers synthesizers by tx_rx_select level
// - rising tx_rx_select in alert: rx off, tx on, tx calibration
// - falling tx_rx_select in alert: tx off, rx on, rx calibration
// - in tdd mode, tx_rx_select in alert picks next state (fdd always goes to rx), taken at next enable edge
// - vco calibration duration is programmable
// - vtune out bits route tune voltage to matching external_lo_input pin
// - lock count codes 0..3 select 256, 512, 1024, 2048 reference cycles
// - lock indication rises when lock achieved within the window
// - lock mode: 0 off, 1 once at enable, 2 continuous, 3 unused
// - fdd runs both synthesizers together; tdd alternates them
// - vco_cal_inhibit suppresses every calibration trigger until cleared
// - calibration result is kept through power down
module rf_synth_cal_lock_control
  import synth_ctl_pkg::*;
#(
  parameter int cal_len_max_width = cal_len_width
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // avalon-mm slave
  input wire avalon_req_t bus_req_in,
  output avalon_rsp_t bus_rsp_out,
  // baseband pins
  input wire logic enable_in,
  input wire logic tx_rx_select_in,
  // loop reference cycle strobe and analog compare per synthesizer (0 rx, 1 tx)
  input wire logic ref_tick_in,
  input wire logic [1:0] phase_ok_in,
  // synthesizer controls
  output logic [1:0] synth_power_out,
  output logic [1:0] vco_cal_busy_out,
  output logic [1:0] lock_out,
  output logic [1:0] vtune_route_out,
  output logic [5:0] ref_scale_out,
  output logic [11:0] cp_current_out,
  output logic [39:0] loop_filter_out
);

  // registers
  logic [5:0] ref_scale;
  logic [cp_code_width-1:0] cp_code [2];
  logic [lf_component_count*lf_code_width-1:0] lf_code [2];
  logic [31:0] int_word [2];
  logic [cal_len_max_width-1:0] cal_len;
  logic cal_inhibit;
  logic [1:0] vtune_sel;
  logic [1:0] lock_count;
  lock_mode_t lock_mode;
  logic tdd_mode;
  logic pin_ctrl;
  logic waiting;
  logic [31:0] rdata;

  radio_state_t radio_state;
  logic enable_prev;
  logic txrx_prev;
  syn_state_t syn_state [2];
  logic [cal_len_max_width-1:0] cal_cnt [2];
  logic [11:0] lock_cnt [2];
  logic once_done [2];
  logic [1:0] powered;

  // bus decode
  wire avalon_req_t rq = bus_req_in;
  wire do_write = rq.write && waiting;
  // read data captured when the request is first seen, so it stands at the accepting edge
  wire do_read = rq.read && !waiting;
  wire hit_scale = rq.address == reg_ref_scale;
  wire hit_cp = rq.address == reg_cp_current;
  wire hit_lf_rx = rq.address == reg_loop_filter_rx;
  wire hit_lf_tx = rq.address == reg_loop_filter_tx;
  wire hit_int_rx = rq.address == reg_int_word_rx;
  wire hit_int_tx = rq.address == reg_int_word_tx;
  wire hit_cal = rq.address == reg_cal_ctrl;
  wire hit_lock = rq.address == reg_lock_cfg;
  wire hit_status = rq.address == reg_status;
  wire hit_mode = rq.address == reg_mode;

  // integer word low byte write is a calibration trigger
  wire [1:0] int_low_write = {do_write && hit_int_tx, do_write && hit_int_rx};

  // radio state machine edges
  wire enable_edge = enable_in != enable_prev;
  wire txrx_rise = tx_rx_select_in && !txrx_prev;
  wire txrx_fall = !tx_rx_select_in && txrx_prev;
  wire in_alert = radio_state == st_alert;
  wire wait_to_alert = radio_state == st_wait && enable_edge;
  wire tdd_pins = tdd_mode && pin_ctrl;

  // desired power per synthesizer
  logic [1:0] next_powered;
  always_comb begin
    next_powered = powered;
    if (radio_state == st_wait) begin
      next_powered = 2'b00;
    end else if (!tdd_mode) begin
      next_powered = 2'b11;
    end else if (in_alert && tdd_pins) begin
      next_powered = tx_rx_select_in ? 2'b10 : 2'b01;
    end else if (radio_state == st_rx) begin
      next_powered = 2'b01;
    end else if (radio_state == st_tx) begin
      next_powered = 2'b10;
    end
  end

  // calibration triggers: power-up into alert, wait-to-alert, integer word write
  wire [1:0] power_up = next_powered & ~powered;
  wire [1:0] cal_trigger = cal_inhibit ? 2'b00 :
    (int_low_write | (power_up & {2{tdd_mode}}) | ({2{wait_to_alert}} & next_powered) |
    ({2{wait_to_alert && !tdd_mode}}) | ({txrx_rise, txrx_fall} & {2{in_alert && tdd_pins}}));

  // lock window length: base shifted by code
  wire [11:0] lock_window = 12'(lock_base_cycles << lock_count);

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      radio_state <= st_wait;
      enable_prev <= 1'b0;
      txrx_prev <= 1'b0;
      powered <= 2'b00;
    end else begin
      enable_prev <= enable_in;
      txrx_prev <= tx_rx_select_in;
      powered <= next_powered;
      case (radio_state)
        st_wait: begin
          if (enable_edge) begin
            radio_state <= st_alert;
          end
        end
        st_alert: begin
          if (enable_edge) begin
            radio_state <= (tdd_mode && tx_rx_select_in) ? st_tx : st_rx;
          end
        end
        default: begin
          if (enable_edge) begin
            radio_state <= st_alert;
          end
        end
      endcase
    end
  end

  // per-synthesizer calibration and lock detection
  for (genvar s = 0; s < 2; s++) begin : g_syn
    wire lock_run = lock_mode == lock_cont || (lock_mode == lock_once && !once_done[s]);
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        syn_state[s] <= syn_off;
        cal_cnt[s] <= '0;
        lock_cnt[s] <= 12'h000;
        once_done[s] <= 1'b0;
      end else if (!next_powered[s] && !cal_trigger[s]) begin
        // calibration result lives in the analog core and survives this
        syn_state[s] <= syn_off;
        lock_cnt[s] <= 12'h000;
        once_done[s] <= 1'b0;
      end else if (cal_trigger[s]) begin
        syn_state[s] <= syn_cal;
        cal_cnt[s] <= cal_len;
        lock_cnt[s] <= 12'h000;
        once_done[s] <= 1'b0;
      end else begin
        case (syn_state[s])
          syn_off: begin
            syn_state[s] <= syn_locking;
            lock_cnt[s] <= 12'h000;
          end
          syn_cal: begin
            if (cal_cnt[s] == '0) begin
              syn_state[s] <= syn_locking;
            end else begin
              cal_cnt[s] <= cal_cnt[s] - cal_len_max_width'(1);
            end
          end
          syn_locking: begin
            if (!phase_ok_in[s]) begin
              lock_cnt[s] <= 12'h000;
            end else if (ref_tick_in && lock_run) begin
              if (lock_cnt[s] + 12'h001 >= lock_window) begin
                syn_state[s] <= syn_locked;
                once_done[s] <= 1'b1;
              end else begin
                lock_cnt[s] <= lock_cnt[s] + 12'h001;
              end
            end
          end
          default: begin
            // continuous mode drops lock on a phase fault
            if (lock_mode == lock_cont && !phase_ok_in[s]) begin
              syn_state[s] <= syn_locking;
              lock_cnt[s] <= 12'h000;
            end else if (lock_mode == lock_off) begin
              syn_state[s] <= syn_locking;
            end
          end
        endcase
      end
    end
  end

  // register writes
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ref_scale <= {scale_pass, scale_pass, scale_pass};
      cp_code[0] <= '0;
      cp_code[1] <= '0;
      lf_code[0] <= '0;
      lf_code[1] <= '0;
      int_word[0] <= read_zero;
      int_word[1] <= read_zero;
      cal_len <= cal_len_max_width'(cal_len_reset);
      cal_inhibit <= 1'b0;
      vtune_sel <= 2'b00;
      lock_count <= 2'b00;
      lock_mode <= lock_off;
      tdd_mode <= 1'b0;
      pin_ctrl <= 1'b0;
    end else if (do_write) begin
      if (hit_scale) begin
        ref_scale <= rq.writedata[5:0];
      end else if (hit_cp) begin
        cp_code[0] <= rq.writedata[cp_code_width-1:0];
        cp_code[1] <= rq.writedata[8+cp_code_width-1:8];
      end else if (hit_lf_rx) begin
        lf_code[0] <= rq.writedata[19:0];
      end else if (hit_lf_tx) begin
        lf_code[1] <= rq.writedata[19:0];
      end else if (hit_int_rx) begin
        int_word[0] <= rq.writedata;
      end else if (hit_int_tx) begin
        int_word[1] <= rq.writedata;
      end else if (hit_cal) begin
        cal_len <= rq.writedata[cal_len_lsb +: cal_len_max_width];
        cal_inhibit <= rq.writedata[cal_inhibit_bit];
        vtune_sel <= {rq.writedata[vtune_tx_bit], rq.writedata[vtune_rx_bit]};
      end else if (hit_lock) begin
        lock_count <= rq.writedata[lock_count_lsb +: 2];
        lock_mode <= lock_mode_t'(rq.writedata[lock_mode_lsb +: 2]);
      end else if (hit_mode) begin
        tdd_mode <= rq.writedata[mode_tdd_bit];
        pin_ctrl <= rq.writedata[mode_pin_ctrl_bit];
      end
    end
  end

  // read mux
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = read_zero;
    if (hit_scale) begin
      next_rdata[5:0] = ref_scale;
    end else if (hit_cp) begin
      next_rdata[cp_code_width-1:0] = cp_code[0];
      next_rdata[8+cp_code_width-1:8] = cp_code[1];
    end else if (hit_lf_rx) begin
      next_rdata[19:0] = lf_code[0];
    end else if (hit_lf_tx) begin
      next_rdata[19:0] = lf_code[1];
    end else if (hit_int_rx) begin
      next_rdata = int_word[0];
    end else if (hit_int_tx) begin
      next_rdata = int_word[1];
    end else if (hit_cal) begin
      next_rdata[cal_len_lsb +: cal_len_max_width] = cal_len;
      next_rdata[cal_inhibit_bit] = cal_inhibit;
      next_rdata[vtune_tx_bit] = vtune_sel[1];
      next_rdata[vtune_rx_bit] = vtune_sel[0];
    end else if (hit_lock) begin
      next_rdata[lock_count_lsb +: 2] = lock_count;
      next_rdata[lock_mode_lsb +: 2] = lock_mode;
    end else if (hit_status) begin
      next_rdata[1:0] = lock_out;
      next_rdata[3:2] = vco_cal_busy_out;
      next_rdata[5:4] = synth_power_out;
      next_rdata[7:6] = radio_state;
    end else if (hit_mode) begin
      next_rdata[mode_tdd_bit] = tdd_mode;
      next_rdata[mode_pin_ctrl_bit] = pin_ctrl;
    end
  end

  // one wait state on every access keeps readdata registered
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      waiting <= 1'b0;
      rdata <= read_zero;
    end else begin
      waiting <= (rq.read || rq.write) && !waiting;
      rdata <= do_read ? next_rdata : rdata;
    end
  end

  // registered outputs
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      bus_rsp_out <= '{readdata: read_zero, waitrequest: 1'b1};
      synth_power_out <= 2'b00;
      vco_cal_busy_out <= 2'b00;
      lock_out <= 2'b00;
      vtune_route_out <= 2'b00;
      ref_scale_out <= '0;
      cp_current_out <= '0;
      loop_filter_out <= '0;
    end else begin
      bus_rsp_out.waitrequest <= !((rq.read || rq.write) && !waiting);
      bus_rsp_out.readdata <= do_read ? next_rdata : rdata;
      synth_power_out <= next_powered;
      vco_cal_busy_out <= {syn_state[1] == syn_cal, syn_state[0] == syn_cal};
      lock_out <= {syn_state[1] == syn_locked && next_powered[1],
        syn_state[0] == syn_locked && next_powered[0]};
      vtune_route_out <= vtune_sel;
      ref_scale_out <= ref_scale;
      cp_current_out <= {cp_code[1], cp_code[0]};
      loop_filter_out <= {lf_code[1], lf_code[0]};
    end
  end

endmodule : rf_synth_cal_lock_control

// ===== tb/baseband_model.sv
`timescale 1ns/1ps
module baseband_model (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // commands from the bench
  input wire logic toggle_in,
  input wire logic select_in,
  // pins toward the device
  output logic enable_out,
  output logic tx_rx_select_out
);
  // pins held quiet through reset so no edge is taken early
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      enable_out <= 1'b0;
      tx_rx_select_out <= 1'b0;
    end else begin
      tx_rx_select_out <= select_in;
      if (toggle_in) begin
        enable_out <= ~enable_out;
      end
    end
  end
endmodule : baseband_model

// ===== tb/rf_synth_cal_lock_control_chk.sv
`timescale 1ns/1ps
module rf_synth_cal_lock_control_chk
  import synth_ctl_pkg::*;
#(
  parameter int cal_len_max_width = cal_len_width
) (
  // clock, reset, bus
  input wire logic clock_in,
  input wire logic srst_in,
  input wire avalon_req_t bus_req_in,
  input wire avalon_rsp_t bus_rsp_out,
  // synthesizer side
  input wire logic [1:0] phase_ok_in,
  input wire logic [1:0] synth_power_out,
  input wire logic [1:0] vco_cal_busy_out,
  input wire logic [1:0] lock_out,
  input wire logic [1:0] vtune_route_out,
  input wire logic [5:0] ref_scale_out,
  input wire logic [11:0] cp_current_out
);
  logic [31:0] last_wd;
  // one access at a time, so the last accepted data is still current two edges on
  always_ff @(posedge clock_in) begin
    if (bus_req_in.write && !bus_rsp_out.waitrequest) begin
      last_wd <= bus_req_in.writedata;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  sequence taken(logic [7:0] a);
    bus_req_in.write && !bus_rsp_out.waitrequest && bus_req_in.address == a;
  endsequence
  sequence waiting;
    (bus_req_in.read || bus_req_in.write) && bus_rsp_out.waitrequest;
  endsequence
  chk_one_wait_state: assert property (waiting |=> !bus_rsp_out.waitrequest)
    else $error("waitrequest held past one cycle");
  chk_wait_pulse_once: assert property (!bus_rsp_out.waitrequest |=> bus_rsp_out.waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_unmapped_reads_zero: assert property (bus_req_in.read && !bus_rsp_out.waitrequest
    && bus_req_in.address > reg_mode |-> bus_rsp_out.readdata == read_zero)
    else $error("unmapped read not zero");
  chk_scale_follows_write: assert property (taken(reg_ref_scale) |-> ##[1:2] ref_scale_out == last_wd[5:0])
    else $error("reference scaler setting not applied");
  chk_cp_follows_write: assert property (taken(reg_cp_current)
    |-> ##[1:2] cp_current_out == {last_wd[13:8], last_wd[5:0]})
    else $error("charge pump code not applied");
  chk_vtune_follows: assert property (taken(reg_cal_ctrl) |-> ##[1:2] vtune_route_out == last_wd[18:17])
    else $error("tune voltage route not applied");
  chk_lock_low_cal: assert property ((vco_cal_busy_out & $past(vco_cal_busy_out) & lock_out) == 2'b00)
    else $error("lock high during calibration");
  chk_lock_low_off: assert property ((~synth_power_out & ~$past(synth_power_out) & lock_out) == 2'b00)
    else $error("lock high while powered down");
  chk_lock_needs_phase: assert property ((lock_out & ~$past(lock_out) & ~$past(phase_ok_in)) == 2'b00)
    else $error("lock rose without phase compare");
endmodule : rf_synth_cal_lock_control_chk

bind rf_synth_cal_lock_control rf_synth_cal_lock_control_chk #(.cal_len_max_width(cal_len_max_width)) i_chk (
  .clock_in(clock_in), .srst_in(srst_in), .bus_req_in(bus_req_in), .bus_rsp_out(bus_rsp_out),
  .phase_ok_in(phase_ok_in), .synth_power_out(synth_power_out), .vco_cal_busy_out(vco_cal_busy_out),
  .lock_out(lock_out), .vtune_route_out(vtune_route_out), .ref_scale_out(ref_scale_out),
  .cp_current_out(cp_current_out));

// ===== tb/rf_synth_cal_lock_control_tb.sv
`timescale 1ns/1ps
module rf_synth_cal_lock_control_tb;
  import synth_ctl_pkg::*;
  logic clock_in, srst_in, toggle, select, enable, tx_rx_sel, ref_tick;
  logic [1:0] phase_ok, power, busy, lock, vtune;
  logic [5:0] scale;
  logic [11:0] cp;
  logic [39:0] lf;
  logic [31:0] q;
  avalon_req_t req;
  avalon_rsp_t rsp;
  int fail_count = 0;
  int n_compared = 0;
  int cnt;

  rf_synth_cal_lock_control i_rf_synth_cal_lock_control (.clock_in(clock_in), .srst_in(srst_in),
    .bus_req_in(req), .bus_rsp_out(rsp), .enable_in(enable), .tx_rx_select_in(tx_rx_sel),
    .ref_tick_in(ref_tick), .phase_ok_in(phase_ok), .synth_power_out(power), .vco_cal_busy_out(busy),
    .lock_out(lock), .vtune_route_out(vtune), .ref_scale_out(scale), .cp_current_out(cp),
    .loop_filter_out(lf));
  baseband_model i_baseband_model (.clock_in(clock_in), .srst_in(srst_in), .toggle_in(toggle),
    .select_in(select), .enable_out(enable), .tx_rx_select_out(tx_rx_sel));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  // request held until the rising edge that samples waitrequest low; a hang is left to the watchdog
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    req <= '{a, ~w, w, d};
    do begin
      @(posedge clock_in);
    end while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req <= '{8'h00, 1'b0, 1'b0, 32'h0000_0000};
  endtask : bus

  task busy_run(input int b);
    cnt = 0;
    repeat (40) begin
      @(negedge clock_in);
      if (busy[b] === 1'b1) cnt++;
    end
  endtask : busy_run

  // first cycles skipped: lock may still show the old state right after a trigger
  task wait_lock(input int b);
    repeat (3) @(negedge clock_in);
    cnt = 3;
    while (lock[b] !== 1'b1 && cnt < 3000) begin
      @(negedge clock_in);
      cnt++;
    end
    if (cnt >= 3000) fail_count++;
  endtask : wait_lock

  task en_edge;
    @(posedge clock_in);
    toggle <= 1'b1;
    @(posedge clock_in);
    toggle <= 1'b0;
  endtask : en_edge

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200_000;
    fail_count++;
    end_of_test();
  end

  initial begin
    srst_in = 1'b1;
    toggle = 1'b0;
    select = 1'b0;
    ref_tick = 1'b1;
    phase_ok = 2'b11;
    req = '{8'h00, 1'b0, 1'b0, 32'h0000_0000};
    repeat (3) @(posedge clock_in);
    check("wait in reset", rsp.waitrequest, 1'b1);
    check("lock reset", lock, 2'b00);
    srst_in <= 1'b0;
    bus(1'b1, reg_ref_scale, 32'h0000_0039);
    bus(1'b1, reg_cp_current, 32'h0000_2a3f);
    bus(1'b1, reg_loop_filter_rx, 32'h0005_a3c1);
    bus(1'b1, reg_loop_filter_tx, 32'h000f_96e0);
    bus(1'b1, reg_cal_ctrl, 32'h0006_0010);
    bus(1'b0, 8'h28, 32'h0000_0000);
    check("unmapped", q, 32'h0000_0000);
    check("ref_scale", scale, 6'h39);
    check("cp", cp, 12'habf);
    check("loop filter", lf, 40'hf9_6e05_a3c1);
    check("vtune", vtune, 2'b11);
    bus(1'b0, reg_cal_ctrl, 32'h0000_0000);
    check("cal_ctrl", q, 32'h0006_0010);
    bus(1'b1, reg_cal_ctrl, 32'h0000_0010);
    bus(1'b1, reg_lock_cfg, 32'h0000_000a);
    bus(1'b1, reg_mode, 32'h0000_0003);
    en_edge();
    wait_lock(0);
    check("vtune off", vtune, 2'b00);
    bus(1'b0, reg_status, 32'h0000_0000);
    check("alert status", q, 32'h0000_0051);
    @(posedge clock_in);
    select <= 1'b1;
    busy_run(1);
    check("tx cal len", cnt, 17);
    check("power tx", power, 2'b10);
    check("rx unlocked", lock[0], 1'b0);
    wait_lock(1);
    check("tx lock", lock, 2'b10);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, reg_lock_cfg, 32'h0000_0008 | 32'(c));
      bus(1'b1, reg_int_word_tx, 32'h0000_0055);
      wait_lock(1);
      check("window", 1'(cnt >= (256 << c) + 17 && cnt <= (256 << c) + 26), 1'b1);
    end
    @(posedge clock_in);
    select <= 1'b0;
    busy_run(0);
    check("rx cal len", cnt, 17);
    check("power rx", power, 2'b01);
    check("tx unlocked", lock[1], 1'b0);
    bus(1'b1, reg_cal_ctrl, 32'h0001_0010);
    bus(1'b1, reg_int_word_rx, 32'h0000_0033);
    busy_run(0);
    check("inhibit word", cnt, 0);
    @(posedge clock_in);
    select <= 1'b1;
    busy_run(1);
    check("inhibit select", cnt, 0);
    check("power kept", power, 2'b10);
    wait_lock(1);
    check("relock", lock, 2'b10);
    en_edge();
    bus(1'b0, reg_status, 32'h0000_0000);
    check("state tx", q[7:6], 2'b10);
    en_edge();
    bus(1'b0, reg_status, 32'h0000_0000);
    check("state alert", q[7:6], 2'b01);
    bus(1'b1, reg_cal_ctrl, 32'h0000_0010);
    bus(1'b1, reg_lock_cfg, 32'h0000_0000);
    bus(1'b1, reg_int_word_tx, 32'h0000_0055);
    repeat (400) @(negedge clock_in);
    check("lock disabled", lock, 2'b00);
    bus(1'b1, reg_lock_cfg, 32'h0000_0008);
    wait_lock(1);
    check("cont lock", lock, 2'b10);
    @(posedge clock_in);
    phase_ok <= 2'b01;
    repeat (4) @(negedge clock_in);
    check("cont drop", lock, 2'b00);
    bus(1'b1, reg_lock_cfg, 32'h0000_0004);
    phase_ok <= 2'b11;
    bus(1'b1, reg_int_word_tx, 32'h0000_0055);
    wait_lock(1);
    check("once lock", lock, 2'b10);
    @(posedge clock_in);
    phase_ok <= 2'b01;
    repeat (4) @(negedge clock_in);
    check("once hold", lock, 2'b10);
    bus(1'b1, reg_mode, 32'h0000_0000);
    repeat (2) @(negedge clock_in);
    check("fdd power", power, 2'b11);
    end_of_test();
  end
endmodule : rf_synth_cal_lock_control_tb
